// file: logic/gpt_pkg.sv
package gpt_pkg;
   // ***************************************************************
   // register map
   // ***************************************************************
   localparam logic [15:0] ADDR_OVERALL_CTRL = 16'h7400;
   localparam logic [15:0] ADDR_T1_CTRL = 16'h7404;
   localparam logic [15:0] ADDR_T2_CTRL = 16'h7408;
   localparam logic [15:0] ADDR_T1_CNT = 16'h7401;
   localparam logic [15:0] ADDR_T1_CMP = 16'h7402;
   localparam logic [15:0] ADDR_T1_PER = 16'h7403;
   localparam logic [15:0] ADDR_T2_CNT = 16'h7405;
   localparam logic [15:0] ADDR_T2_CMP = 16'h7406;
   localparam logic [15:0] ADDR_T2_PER = 16'h7407;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'hDFFF;
   localparam logic [15:0] T1_CTRL_WMASK = 16'hDF7E;
   localparam logic [15:0] OVR_WMASK = 16'h004F;
   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int EMU_HI = 15;
   localparam int EMU_LO = 14;
   localparam int MODE_HI = 12;
   localparam int MODE_LO = 11;
   localparam int PSC_HI = 10;
   localparam int PSC_LO = 8;
   localparam int SWT1_BIT = 7;
   localparam int EN_BIT = 6;
   localparam int CLKS_HI = 5;
   localparam int CLKS_LO = 4;
   localparam int RLD_HI = 3;
   localparam int RLD_LO = 2;
   localparam int CMPEN_BIT = 1;
   localparam int PERSEL_BIT = 0;
   localparam int OE_BIT = 6;
   localparam int T2STAT_BIT = 14;
   localparam int T1STAT_BIT = 13;
   // ***************************************************************
   // encodings
   // ***************************************************************
   localparam logic [1:0] MODE_HOLD = 2'h0;
   localparam logic [1:0] MODE_UPDN = 2'h1;
   localparam logic [1:0] MODE_UP = 2'h2;
   localparam logic [1:0] MODE_DIR = 2'h3;
   localparam logic [1:0] POL_LOW = 2'h0;
   localparam logic [1:0] POL_ALOW = 2'h1;
   localparam logic [1:0] POL_AHIGH = 2'h2;
   localparam logic [1:0] POL_HIGH = 2'h3;
   localparam logic [1:0] RLD_ZERO = 2'h0;
   localparam logic [1:0] RLD_ZPER = 2'h1;
   localparam logic [1:0] RLD_IMM = 2'h2;
   localparam logic [1:0] EMU_NOW = 2'h0;
   localparam logic [1:0] EMU_END = 2'h1;
   localparam logic [1:0] CLK_INT = 2'h0;
   localparam logic [1:0] CLK_EXT = 2'h1;
   localparam logic [1:0] CLK_QEP = 2'h3;
endpackage

// file: logic/gpt_timer_pwm.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module gpt_timer_pwm
   import gpt_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // register port
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // pins and system inputs
   input wire logic tclkin_i,
   input wire logic tdir_i,
   input wire logic qep_clk_i,
   input wire logic qep_dir_i,
   input wire logic protect_n_i,
   input wire logic protect_mask_i,
   input wire logic emu_suspend_i,
   // pwm outputs
   output logic [1:0] pwm_o,
   output logic [1:0] pwm_oe_o,
   output logic [1:0] cmp_flag_o
);
   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic [1:0][15:0] ctrl;
      logic [1:0][15:0] cnt;
      logic [1:0][15:0] per;
      logic [1:0][15:0] cmp_sh;
      logic [1:0][15:0] cmp_act;
      logic [1:0][6:0] psc;
      logic [1:0] dir_up;
      logic [1:0] wave;
      logic [1:0] emu_stop;
      logic [1:0] cflag;
      logic [15:0] ovr;
      logic [15:0] rdata;
      logic [2:0] s_ext;
      logic [2:0] s_qc;
      logic [1:0] s_tdir;
      logic [1:0] s_qdir;
      logic [1:0] s_prot;
   } gpt_state_s;

   gpt_state_s st_ff, nxt_st;

   // prescaler terminal test, divide by 2^sel
   function automatic logic psc_done(input logic [6:0] c, input logic [2:0] sel);
      logic [6:0] lim;
      lim = 7'((8'h01 << sel) - 8'h01);
      return (c >= lim);
   endfunction

   logic [1:0] en_eff, tick, run, m_cmp, m_per, m_zero;
   logic [1:0][15:0] per_eff;
   logic ext_rise, qc_rise, prot_trip;

   // pin edges use only the second and third stages of each synchroniser
   assign ext_rise = st_ff.s_ext[1] & ~st_ff.s_ext[2];
   assign qc_rise = st_ff.s_qc[1] & ~st_ff.s_qc[2];
   assign prot_trip = ~st_ff.s_prot[1] & ~protect_mask_i;

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.s_ext = {st_ff.s_ext[1:0], tclkin_i};
      nxt_st.s_qc = {st_ff.s_qc[1:0], qep_clk_i};
      nxt_st.s_tdir = {st_ff.s_tdir[0], tdir_i};
      nxt_st.s_qdir = {st_ff.s_qdir[0], qep_dir_i};
      nxt_st.s_prot = {st_ff.s_prot[0], protect_n_i};
      nxt_st.cflag = 2'h0;
      for (int t = 0; t < 2; t++) begin
         // timer2 follows timer1 enable on request
         en_eff[t] = (t == 1 && st_ff.ctrl[1][SWT1_BIT]) ? st_ff.ctrl[0][EN_BIT] : st_ff.ctrl[t][EN_BIT];
         // shared period register when selected
         per_eff[t] = (t == 1 && st_ff.ctrl[1][PERSEL_BIT]) ? st_ff.per[0] : st_ff.per[t];
         // emulation suspend handling
         run[t] = en_eff[t] && !st_ff.emu_stop[t] && st_ff.ctrl[t][MODE_HI:MODE_LO] != MODE_HOLD;
         if (emu_suspend_i && st_ff.ctrl[t][EMU_HI:EMU_LO] == EMU_NOW) begin
            run[t] = 1'b0;
         end
         tick[t] = 1'b0;
         m_cmp[t] = 1'b0;
         m_per[t] = 1'b0;
         m_zero[t] = 1'b0;
         if (!en_eff[t]) begin
            nxt_st.psc[t] = 7'h00; // disable clears prescaler, holds counter
         end else if (run[t]) begin
            // clock source select
            unique case (st_ff.ctrl[t][CLKS_HI:CLKS_LO])
               CLK_EXT: tick[t] = ext_rise;
               CLK_QEP: tick[t] = (t == 1 && !st_ff.ctrl[1][PERSEL_BIT]) ? qc_rise : 1'b0;
               CLK_INT: tick[t] = 1'b1;
               default: tick[t] = 1'b0;
            endcase
            // power-of-two prescale
            if (tick[t]) begin
               if (psc_done(st_ff.psc[t], st_ff.ctrl[t][PSC_HI:PSC_LO])) begin
                  nxt_st.psc[t] = 7'h00;
               end else begin
                  nxt_st.psc[t] = st_ff.psc[t] + 7'h01;
                  tick[t] = 1'b0;
               end
            end
         end
         // counting modes
         if (tick[t]) begin
            unique case (st_ff.ctrl[t][MODE_HI:MODE_LO])
               MODE_UP: begin
                  m_per[t] = (st_ff.cnt[t] == per_eff[t]);
                  nxt_st.cnt[t] = m_per[t] ? 16'h0000 : st_ff.cnt[t] + 16'h0001;
                  nxt_st.dir_up[t] = 1'b1;
               end
               MODE_UPDN, MODE_DIR: begin
                  if (st_ff.ctrl[t][MODE_HI:MODE_LO] == MODE_DIR) begin
                     nxt_st.dir_up[t] = (t == 1 && st_ff.ctrl[1][CLKS_HI:CLKS_LO] == CLK_QEP) ?
                        st_ff.s_qdir[1] : st_ff.s_tdir[1];
                  end
                  if (st_ff.dir_up[t]) begin
                     m_per[t] = (st_ff.cnt[t] == per_eff[t]);
                     if (m_per[t]) begin
                        nxt_st.dir_up[t] = 1'b0;
                        nxt_st.cnt[t] = st_ff.cnt[t] - 16'h0001;
                     end else begin
                        nxt_st.cnt[t] = st_ff.cnt[t] + 16'h0001;
                     end
                  end else if (st_ff.cnt[t] == 16'h0000) begin
                     nxt_st.dir_up[t] = 1'b1;
                     nxt_st.cnt[t] = 16'h0001;
                  end else begin
                     nxt_st.cnt[t] = st_ff.cnt[t] - 16'h0001;
                  end
               end
               default: ;
            endcase
            m_zero[t] = (st_ff.cnt[t] == 16'h0000);
            // emulation stop at end of period
            if (emu_suspend_i && st_ff.ctrl[t][EMU_HI:EMU_LO] == EMU_END && m_per[t]) begin
               nxt_st.emu_stop[t] = 1'b1;
            end
            // compare match, flag and wave one clock later
            m_cmp[t] = st_ff.ctrl[t][CMPEN_BIT] && (st_ff.cnt[t] == st_ff.cmp_act[t]) &&
               (st_ff.cmp_act[t] < per_eff[t] || st_ff.ctrl[t][MODE_HI:MODE_LO] == MODE_UP);
         end
         if (!emu_suspend_i) begin
            nxt_st.emu_stop[t] = 1'b0;
         end
         // shadow reload
         unique case (st_ff.ctrl[t][RLD_HI:RLD_LO])
            RLD_ZERO: if (m_zero[t]) nxt_st.cmp_act[t] = st_ff.cmp_sh[t];
            RLD_ZPER: if (m_zero[t] || m_per[t]) nxt_st.cmp_act[t] = st_ff.cmp_sh[t];
            RLD_IMM: nxt_st.cmp_act[t] = st_ff.cmp_sh[t];
            default: ;
         endcase
         // waveform generator, every transition one clock after its match
         if (m_cmp[t]) begin
            nxt_st.wave[t] = ~st_ff.wave[t];
            nxt_st.cflag[t] = 1'b1;
         end
         // period start in every mode: resetting on the zero count rather than the period
         // match keeps both edges equally delayed, so in up mode the pulse is period-compare+1 wide
         if (m_zero[t]) begin
            nxt_st.wave[t] = (nxt_st.cmp_act[t] == 16'h0000);
         end
         if (!st_ff.ctrl[t][CMPEN_BIT]) begin
            nxt_st.wave[t] = 1'b0;
         end
      end
      // protect input drops the global enable
      if (prot_trip) begin
         nxt_st.ovr[OE_BIT] = 1'b0;
      end
      // register writes; reserved bits masked
      if (wr_i) begin
         unique case (addr_i)
            ADDR_T1_CTRL: nxt_st.ctrl[0] = wdata_i & T1_CTRL_WMASK;
            ADDR_T2_CTRL: nxt_st.ctrl[1] = wdata_i & CTRL_WMASK;
            ADDR_T1_CNT: nxt_st.cnt[0] = wdata_i;
            ADDR_T2_CNT: nxt_st.cnt[1] = wdata_i;
            ADDR_T1_CMP: nxt_st.cmp_sh[0] = wdata_i;
            ADDR_T2_CMP: nxt_st.cmp_sh[1] = wdata_i;
            ADDR_T1_PER: nxt_st.per[0] = wdata_i;
            ADDR_T2_PER: nxt_st.per[1] = wdata_i;
            ADDR_OVERALL_CTRL: nxt_st.ovr = (wdata_i & OVR_WMASK) & {9'h1FF, ~prot_trip, 6'h3F};
            default: ;
         endcase
      end
      // read data stand one cycle after the strobe
      nxt_st.rdata = 16'h0000;
      if (rd_i) begin
         unique case (addr_i)
            ADDR_T1_CTRL: nxt_st.rdata = st_ff.ctrl[0];
            ADDR_T2_CTRL: nxt_st.rdata = st_ff.ctrl[1];
            ADDR_T1_CNT: nxt_st.rdata = st_ff.cnt[0];
            ADDR_T2_CNT: nxt_st.rdata = st_ff.cnt[1];
            ADDR_T1_CMP: nxt_st.rdata = st_ff.cmp_sh[0];
            ADDR_T2_CMP: nxt_st.rdata = st_ff.cmp_sh[1];
            ADDR_T1_PER: nxt_st.rdata = st_ff.per[0];
            ADDR_T2_PER: nxt_st.rdata = st_ff.per[1];
            ADDR_OVERALL_CTRL: begin
               nxt_st.rdata = st_ff.ovr;
               nxt_st.rdata[T2STAT_BIT] = st_ff.dir_up[1];
               nxt_st.rdata[T1STAT_BIT] = st_ff.dir_up[0];
            end
            default: nxt_st.rdata = 16'h0000;
         endcase
      end
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         // direction status reads as counting up and protect as idle high after reset
         st_ff <= '0;
         st_ff.dir_up <= 2'h3;
         st_ff.s_prot <= 2'h3;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ***************************************************************
   // output logic
   // ***************************************************************
   always_comb begin
      rdata_o = st_ff.rdata;
      cmp_flag_o = st_ff.cflag;
      for (int t = 0; t < 2; t++) begin
         // polarity decode
         unique case (st_ff.ovr[2*t+1 -: 2])
            POL_LOW: pwm_o[t] = 1'b0;
            POL_ALOW: pwm_o[t] = ~st_ff.wave[t];
            POL_AHIGH: pwm_o[t] = st_ff.wave[t];
            POL_HIGH: pwm_o[t] = 1'b1;
            default: pwm_o[t] = 1'b0;
         endcase
         // tri-state conditions
         pwm_oe_o[t] = st_ff.ovr[OE_BIT] & st_ff.ctrl[t][CMPEN_BIT] & ~prot_trip;
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   property p_oe_off;
      @(posedge mclk_i) disable iff (rst_i) !st_ff.ovr[OE_BIT] |-> pwm_oe_o == 2'h0;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("pwm driven with output enable clear");

   property p_forced_high;
      @(posedge mclk_i) disable iff (rst_i) st_ff.ovr[1:0] == POL_HIGH |-> pwm_o[0];
   endproperty
   a_forced_high: assert property (p_forced_high) else $error("forced high not high");

   property p_flag_delay;
      @(posedge mclk_i) disable iff (rst_i) m_cmp[0] && !m_per[0] && !m_zero[0] |=> cmp_flag_o[0];
   endproperty
   a_flag_delay: assert property (p_flag_delay) else $error("compare flag late");

   property p_follow;
      @(posedge mclk_i) disable iff (rst_i) st_ff.ovr[1:0] == POL_ALOW |-> pwm_o[0] == ~st_ff.wave[0];
   endproperty
   a_follow: assert property (p_follow) else $error("active low not inverted");

   property p_res13;
      @(posedge mclk_i) disable iff (rst_i) st_ff.ctrl[0][13] == 1'b0 && st_ff.ctrl[1][13] == 1'b0;
   endproperty
   a_res13: assert property (p_res13) else $error("reserved bit set");

   property p_hold;
      @(posedge mclk_i) disable iff (rst_i) !en_eff[0] && !wr_i |=> $stable(st_ff.cnt[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("disabled counter moved");

   property p_cmp_off;
      @(posedge mclk_i) disable iff (rst_i) !st_ff.ctrl[1][CMPEN_BIT] |=> !st_ff.wave[1];
   endproperty
   a_cmp_off: assert property (p_cmp_off) else $error("wave with compare off");

   property p_up_per;
      @(posedge mclk_i) disable iff (rst_i)
         m_zero[0] && st_ff.ctrl[0][CMPEN_BIT]
         && !wr_i |=> st_ff.wave[0] == (st_ff.cmp_act[0] == 16'h0000);
   endproperty
   a_up_per: assert property (p_up_per) else $error("period start wave wrong");

   property p_forced_low;
      @(posedge mclk_i) disable iff (rst_i) st_ff.ovr[1:0] == POL_LOW |-> !pwm_o[0];
   endproperty
   a_forced_low: assert property (p_forced_low) else $error("forced low not low");

   property p_t2_high;
      @(posedge mclk_i) disable iff (rst_i) st_ff.ovr[3:2] == POL_AHIGH |-> pwm_o[1] == st_ff.wave[1];
   endproperty
   a_t2_high: assert property (p_t2_high) else $error("active high not following");

   property p_psc_clear;
      @(posedge mclk_i) disable iff (rst_i) !en_eff[0] |=> st_ff.psc[0] == 7'h00;
   endproperty
   a_psc_clear: assert property (p_psc_clear) else $error("prescaler kept while disabled");

   property p_cmp_oe;
      @(posedge mclk_i) disable iff (rst_i) !st_ff.ctrl[0][CMPEN_BIT] |-> !pwm_oe_o[0];
   endproperty
   a_cmp_oe: assert property (p_cmp_oe) else $error("pwm driven with compare off");

   property p_prot_oe;
      @(posedge mclk_i) disable iff (rst_i) prot_trip |-> pwm_oe_o == 2'h0;
   endproperty
   a_prot_oe: assert property (p_prot_oe) else $error("pwm driven during protect");

   property p_t2_follow;
      @(posedge mclk_i) disable iff (rst_i) st_ff.ctrl[1][SWT1_BIT] |-> en_eff[1] == st_ff.ctrl[0][EN_BIT];
   endproperty
   a_t2_follow: assert property (p_t2_follow) else $error("timer2 not following timer1");

   property p_imm_reload;
      @(posedge mclk_i) disable iff (rst_i)
         st_ff.ctrl[0][RLD_HI:RLD_LO] == RLD_IMM |=> st_ff.cmp_act[0] == $past(st_ff.cmp_sh[0]);
   endproperty
   a_imm_reload: assert property (p_imm_reload) else $error("immediate reload missed");

   property p_tick_only;
      @(posedge mclk_i) disable iff (rst_i) !tick[0] && !wr_i |=> $stable(st_ff.cnt[0]);
   endproperty
   a_tick_only: assert property (p_tick_only) else $error("counter moved without tick");

   property p_mode_hold;
      @(posedge mclk_i) disable iff (rst_i) st_ff.ctrl[0][MODE_HI:MODE_LO] == MODE_HOLD |-> !tick[0];
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("tick in hold mode");

   // a debugger halt must freeze the count at once when the field asks for it
   property p_emu_now;
      @(posedge mclk_i) disable iff (rst_i)
         emu_suspend_i && st_ff.ctrl[0][EMU_HI:EMU_LO] == EMU_NOW |-> !tick[0];
   endproperty
   a_emu_now: assert property (p_emu_now) else $error("tick during suspend");
endmodule
`default_nettype wire

// file: dv/gpt_power_stage.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// gate driver behind one timer pwm pin
// ****************************************
module gpt_power_stage (
   // pin side
   input wire logic pwm_i,
   input wire logic pwm_oe_i,
   input wire logic fault_i,
   // gate drive out, protect line back to the timer
   output logic gate_o,
   output logic protect_n_o
);
   // a released pin falls to the driver pull-down, it never keeps its last level
   assign gate_o = pwm_oe_i ? pwm_i : 1'b0;
   // over-current trip holds the protect line low while the fault lasts
   assign protect_n_o = ~fault_i;
endmodule
`default_nettype wire

// file: dv/gpt_timer_pwm_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gpt_timer_pwm_tb;
   import gpt_pkg::*;
   // ****************************************
   // clock, stimulus and observation
   // ****************************************
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic mask_i = 1'b0;
   logic emu_i = 1'b0;
   logic fault = 1'b0;
   logic [15:0] addr_i = 16'h0000;
   logic [15:0] wdata_i = 16'h0000;
   logic [15:0] rdata_o;
   logic [1:0] pwm_o;
   logic [1:0] pwm_oe_o;
   logic [1:0] cmp_flag_o;
   logic gate;
   logic protect_n;
   logic [15:0] a;
   logic [15:0] b;
   logic [15:0] hi;
   logic [15:0] fl;
   logic moved;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   // case table: control, compare, overall control, window, high cycles, flags
   logic [15:0] t_ctl[9] = '{16'h104A, 16'h104A, 16'h104A, 16'h104A, 16'h104A, 16'h114A, 16'h084A, 16'h084A, 16'h084A};
   logic [15:0] t_cmp[9] = '{16'h0003, 16'h0003, 16'h0000, 16'h000A, 16'h0009, 16'h0003, 16'h0003, 16'h0000, 16'h0009};
   logic [15:0] t_ovr[9] = '{16'h0042, 16'h0041, 16'h0042, 16'h0042, 16'h0042, 16'h0042, 16'h0042, 16'h0042, 16'h0042};
   logic [15:0] t_win[9] = '{16'd40, 16'd40, 16'd40, 16'd40, 16'd40, 16'd80, 16'd72, 16'd72, 16'd72};
   logic [15:0] t_hi[9] = '{16'd28, 16'd12, 16'd40, 16'd0, 16'd4, 16'd56, 16'd48, 16'd72, 16'd0};
   logic [15:0] t_fl[9] = '{16'd4, 16'd4, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'd4, 16'd8, 16'hFFFF, 16'hFFFF};

   // 10 MHz clock
   always #50 mclk_i = ~mclk_i;

   gpt_timer_pwm uut (
      .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .tclkin_i(1'b0), .tdir_i(1'b1), .qep_clk_i(1'b0), .qep_dir_i(1'b1),
      .protect_n_i(protect_n), .protect_mask_i(mask_i), .emu_suspend_i(emu_i),
      .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o), .cmp_flag_o(cmp_flag_o)
   );

   gpt_power_stage stage (
      .pwm_i(pwm_o[0]), .pwm_oe_i(pwm_oe_o[0]), .fault_i(fault), .gate_o(gate), .protect_n_o(protect_n)
   );

   // ****************************************
   // bus cycles and comparisons
   // ****************************************
   task automatic wr(input logic [15:0] ad, input logic [15:0] d);
      @(posedge mclk_i);
      addr_i <= ad;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] ad, output logic [15:0] d);
      @(posedge mclk_i);
      addr_i <= ad;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk_i);
   endtask

   // whole periods only, so the count does not depend on phase
   task automatic measure(input logic [15:0] n, output logic [15:0] h, output logic [15:0] f);
      h = 16'h0000;
      f = 16'h0000;
      repeat (n) begin
         @(posedge mclk_i);
         #1;
         h = h + {15'h0000, gate};
         f = f + {15'h0000, cmp_flag_o[0]};
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // hang guard, the sequence needs well under 3000 cycles
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         miscompares++;
         $display("wrong value at %0t: run did not finish", $time);
         give_verdict();
      end
   end

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      idle(16);
      rst_i <= 1'b0;
      chk({14'h0000, pwm_oe_o}, 16'h0000, "oe in reset");
      rd(ADDR_T1_CTRL, a);
      chk(a, 16'h0000, "t1 ctrl reset");
      rd(ADDR_T2_CTRL, a);
      chk(a, 16'h0000, "t2 ctrl reset");
      wr(ADDR_T1_CTRL, 16'hFFFF);
      rd(ADDR_T1_CTRL, a);
      chk(a, 16'hDF7E, "t1 ctrl reserved bits");
      wr(ADDR_T1_CTRL, 16'h0000);
      wr(ADDR_T2_CTRL, 16'hFFFF);
      rd(ADDR_T2_CTRL, a);
      chk(a, 16'hDFFF, "t2 ctrl bit 13");
      wr(ADDR_T2_CTRL, 16'h0000);
      rd(16'h7410, a);
      chk(a, 16'h0000, "unmapped read");
      $display("test registers done");
      wr(ADDR_T1_PER, 16'h0009);
      wr(ADDR_T1_CTRL, 16'h104A);
      wr(ADDR_OVERALL_CTRL, 16'h0043);
      idle(2);
      chk({14'h0000, pwm_oe_o[0], pwm_o[0]}, 16'h0003, "forced high");
      wr(ADDR_OVERALL_CTRL, 16'h0040);
      idle(2);
      chk({15'h0000, pwm_o[0]}, 16'h0000, "forced low");
      $display("test forced levels done");
      // period register 9 (10 ticks up, 18 up-down), one window of four periods per case
      for (int i = 0; i < 9; i++) begin
         wr(ADDR_T1_CMP, t_cmp[i]);
         wr(ADDR_OVERALL_CTRL, t_ovr[i]);
         wr(ADDR_T1_CTRL, t_ctl[i]);
         idle(t_win[i]);
         measure(t_win[i], hi, fl);
         chk(hi, t_hi[i], "active cycles");
         if (t_fl[i] != 16'hFFFF) begin
            chk(fl, t_fl[i], "compare pulses");
         end
      end
      $display("test waveforms done");
      wr(ADDR_T1_CTRL, 16'h104A);
      wr(ADDR_OVERALL_CTRL, 16'h0002);
      idle(2);
      chk({15'h0000, pwm_oe_o[0]}, 16'h0000, "global enable off");
      wr(ADDR_OVERALL_CTRL, 16'h0042);
      fault <= 1'b1;
      idle(6);
      chk({15'h0000, pwm_oe_o[0]}, 16'h0000, "protect trip");
      fault <= 1'b0;
      idle(4);
      wr(ADDR_OVERALL_CTRL, 16'h0042);
      idle(2);
      chk({15'h0000, pwm_oe_o[0]}, 16'h0001, "enable again");
      mask_i <= 1'b1;
      fault <= 1'b1;
      idle(6);
      chk({15'h0000, pwm_oe_o[0]}, 16'h0001, "masked protect");
      fault <= 1'b0;
      idle(4);
      mask_i <= 1'b0;
      wr(ADDR_T1_CTRL, 16'h1048);
      idle(2);
      chk({15'h0000, pwm_oe_o[0]}, 16'h0000, "compare disabled");
      $display("test tri-state done");
      wr(ADDR_T1_CTRL, 16'h1008);
      rd(ADDR_T1_CNT, a);
      rd(ADDR_T1_CNT, b);
      chk(b, a, "disabled counter holds");
      wr(ADDR_T1_CTRL, 16'h0048);
      rd(ADDR_T1_CNT, a);
      rd(ADDR_T1_CNT, b);
      chk(b, a, "hold mode");
      emu_i <= 1'b1;
      wr(ADDR_T1_CTRL, 16'h904A);
      rd(ADDR_T1_CNT, a);
      rd(ADDR_T1_CNT, b);
      chk({15'h0000, a == b}, 16'h0000, "suspend ignored");
      wr(ADDR_T1_CTRL, 16'h104A);
      idle(2);
      rd(ADDR_T1_CNT, a);
      rd(ADDR_T1_CNT, b);
      chk(b, a, "suspend stops now");
      emu_i <= 1'b0;
      $display("test counter control done");
      // timer 2 follows timer 1 enable and borrows its period of 9
      wr(ADDR_T2_PER, 16'hFFFF);
      wr(ADDR_T1_CTRL, 16'h1040);
      wr(ADDR_T2_CTRL, 16'h1081);
      moved = 1'b0;
      rd(ADDR_T2_CNT, a);
      for (int i = 0; i < 6; i++) begin
         rd(ADDR_T2_CNT, b);
         chk({15'h0000, b > 16'h0009}, 16'h0000, "t2 within t1 period");
         moved = moved | (a != b);
      end
      chk({15'h0000, moved}, 16'h0001, "t2 started by t1");
      $display("test timer 2 done");
      give_verdict();
   end
endmodule
`default_nettype wire
